// file: dv/ctab_core_model.sv
// controller-core stand-in: init handshake, bus-off entry and buffer events
`timescale 1ns/100ps
module ctab_core_model (
    input  wire logic       clk_i,      // bus clock
    output logic            init_rq_o,  // init request level
    output logic            init_ak_o,  // init acknowledge level
    output logic            bo_sel_o,   // user recovery select level
    output logic            bo_ent_o,   // bus-off entry pulse
    output logic [2:0]      empty_o,    // buffer empty pulses
    output logic [2:0]      sent_o      // buffer sent pulses
);
    initial begin
        {init_rq_o, init_ak_o, bo_sel_o, bo_ent_o, empty_o, sent_o} = '0;
    end
    // acknowledge trails the request by one cycle, both ways
    task automatic set_init(input logic on);
        @(posedge clk_i) init_rq_o <= on;
        @(posedge clk_i) init_ak_o <= on;
    endtask
    // recovery select, a plain level
    task automatic set_sel(input logic on);
        @(posedge clk_i) bo_sel_o <= on;
    endtask
    // one-cycle pulses on the event lines
    task automatic pulse(input logic [2:0] e, input logic [2:0] s, input logic b);
        @(posedge clk_i) {empty_o, sent_o, bo_ent_o} <= {e, s, b};
        @(posedge clk_i) {empty_o, sent_o, bo_ent_o} <= '0;
    endtask
endmodule

// file: dv/ctab_regs_tb.sv
// self-checking bench for the abort / irq-enable / bus-off register slice
`timescale 1ns/100ps
module ctab_regs_tb;
    import ctab_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rq_l, ak_l, sel_l, ent_l;
    logic busoff_hold_o, recovery_req_o, ce_l;
    logic [7:0]  wb_adr_i;              // byte address
    logic [31:0] wb_dat_i, wb_dat_o;    // bus data
    logic [2:0]  empty, sent, tx_irq_req_o, abort_request_bit_o, ab, n_rec;
    logic [31:0] rq[$];                 // expected read words
    logic [2:0]  iq[$];                 // expected irq pulses
    int errors = 0, n_compared = 0, n_cyc = 0;
    ctab_core_model i_core (.clk_i(clk_i), .init_rq_o(rq_l), .init_ak_o(ak_l),
        .bo_sel_o(sel_l), .bo_ent_o(ent_l), .empty_o(empty), .sent_o(sent));
    ctab_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_l), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .init_mode_request_i(rq_l), .init_mode_acknowledge_i(ak_l),
        .busoff_recovery_select_i(sel_l), .busoff_enter_i(ent_l), .tx_empty_event_i(empty),
        .tx_sent_i(sent), .tx_irq_req_o(tx_irq_req_o), .abort_request_bit_o(abort_request_bit_o),
        .busoff_hold_o(busoff_hold_o), .recovery_req_o(recovery_req_o));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("unexpected read at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_sig(input logic [2:0] e, input logic [2:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("unexpected signal at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    // classic single cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i) {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watcher: read data on ack, irq pulses, recovery pulses, timeout
    always @(posedge clk_i) begin
        n_cyc <= n_cyc + 1;
        if (recovery_req_o === 1'b1) n_rec <= n_rec + 3'h1;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk_rd(rq.size() ? rq.pop_front() : 32'hDEADBEEF, wb_dat_o);
        if (tx_irq_req_o !== 3'h0) chk_sig(iq.size() ? iq.pop_front() : 3'h0, tx_irq_req_o);
        if (n_cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, n_rec} = {1'b1, 43'h0, 3'h0};
        ce_l = 1'b1;
        void'($urandom(32'h13c0263e));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTAB_OFS_TIER, 32'h0); rd(CTAB_OFS_TARQ, 32'h0); rd(8'h1C, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(CTAB_OFS_TIER, 32'(k));
            rd(CTAB_OFS_TIER, 32'(k));
            if (k != 0) iq.push_back(3'(k));
            i_core.pulse(3'h7, 3'h0, 1'b0);
        end
        ab = 3'($urandom) | 3'h1;
        wr(CTAB_OFS_TARQ, 32'(ab)); wr(CTAB_OFS_TARQ, 32'h0); rd(CTAB_OFS_TARQ, 32'(ab));
        i_core.pulse(3'h0, 3'h1, 1'b0); rd(CTAB_OFS_TARQ, 32'(ab & 3'h6));
        wr(CTAB_OFS_TARQ, 32'h7); i_core.set_init(1'b1); wr(CTAB_OFS_TIER, 32'h7); wr(CTAB_OFS_TARQ, 32'h7);
        rd(CTAB_OFS_TIER, 32'h0); rd(CTAB_OFS_TARQ, 32'h0);
        i_core.pulse(3'h7, 3'h0, 1'b0); i_core.set_init(1'b0); rd(CTAB_OFS_TIER, 32'h0);
        wr(CTAB_OFS_TEST, 32'hFF); rd(CTAB_OFS_TEST, 32'h0);
        i_core.set_sel(1'b1);
        @(posedge clk_i) ce_l <= 1'b0;
        i_core.pulse(3'h0, 3'h0, 1'b1);
        @(posedge clk_i) ce_l <= 1'b1;
        rd(CTAB_OFS_MISC, 32'h0);
        i_core.pulse(3'h0, 3'h0, 1'b1); rd(CTAB_OFS_MISC, 32'h1);
        #1 chk_sig(3'h1, {2'b00, busoff_hold_o});
        wr(CTAB_OFS_MISC, 32'h0); rd(CTAB_OFS_MISC, 32'h1);
        wr(CTAB_OFS_MISC, 32'h1); rd(CTAB_OFS_MISC, 32'h0);
        #1 chk_sig(3'h1, n_rec);
        chk_sig(3'h0, 3'(iq.size() + rq.size()));
        give_verdict();
    end
endmodule

// file: hw/ctab_pkg.sv
// package: register map and constants for the transmit-abort / bus-off control slice
package ctab_pkg;
    localparam int          CTAB_AW          = 8;       // wishbone byte address width
    localparam int          CTAB_DW          = 32;      // wishbone data width
    localparam int          CTAB_NBUF        = 3;       // transmit buffers
    localparam logic [7:0]  CTAB_OFS_TIER    = 8'h04;   // tx empty irq enable
    localparam logic [7:0]  CTAB_OFS_TARQ    = 8'h08;   // tx abort request
    localparam logic [7:0]  CTAB_OFS_TEST    = 8'h0C;   // factory test, reads zero
    localparam logic [7:0]  CTAB_OFS_MISC    = 8'h10;   // misc bus-off hold
    localparam logic [7:0]  CTAB_OFS_STAT    = 8'h14;   // irq request / bus-off status
    localparam logic [2:0]  CTAB_RST_BUF     = 3'h0;    // reset of per-buffer registers
    localparam logic [31:0] CTAB_RD_ZERO     = 32'h0;   // read value of zero words
    localparam int          CTAB_HOLD_BIT    = 0;       // bus-off hold flag position
    localparam int          CTAB_STAT_BO_BIT = 3;       // bus-off bit in status word
    localparam int          CTAB_ST_RDY_BIT  = 4;       // hold cleared (recovery may go)
endpackage

// file: hw/ctab_regs.sv
// file: register slice for transmit irq enables, abort requests and bus-off hold
// Overview of operation
// - tx irq enables reset, write-locked during init
// - enabled buffer empty event raises irq request
// - disabled buffer empty event gives no request
// - abort request register at 0x0008, bits 2-0
// - abort requests reset, write-locked during init
// - factory test register reads zero, ignores writes
// - bus-off with recovery select sets hold flag
// - hold flag clears on write one only
// - clearing hold flag requests bus-off recovery
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
module ctab_regs
    import ctab_pkg::*;
(
    input  wire logic                        clk_i,          // bus clock 250 MHz
    input  wire logic                        rst_i,          // sync reset, active high
    input  wire logic                        ce_i,           // clock enable, freezes state
    input  wire logic                        wb_cyc_i,       // wishbone cycle
    input  wire logic                        wb_stb_i,       // wishbone strobe
    input  wire logic                        wb_we_i,        // wishbone write
    input  wire logic [ctab_pkg::CTAB_AW-1:0] wb_adr_i,      // byte address
    input  wire logic [3:0]                  wb_sel_i,       // byte selects
    input  wire logic [ctab_pkg::CTAB_DW-1:0] wb_dat_i,      // write data
    output logic      [ctab_pkg::CTAB_DW-1:0] wb_dat_o,      // read data
    output logic                             wb_ack_o,       // acknowledge
    input  wire logic                        init_mode_request_i,     // init request
    input  wire logic                        init_mode_acknowledge_i, // init acknowledge
    input  wire logic                        busoff_recovery_select_i, // user recovery
    input  wire logic                        busoff_enter_i,  // pulse: entering bus-off
    input  wire logic [2:0]                  tx_empty_event_i, // pulse per buffer empty
    input  wire logic [2:0]                  tx_sent_i,      // pulse per buffer done/aborted
    output logic      [2:0]                  tx_irq_req_o,   // per-buffer irq request
    output logic      [2:0]                  abort_request_bit_o, // abort request per buffer
    output logic                             busoff_hold_o,  // stay bus-off while high
    output logic                             recovery_req_o  // pulse: start recovery
);
    import ctab_pkg::*;

    logic [2:0] tx_buffer_empty_irq_en_reg, tx_buffer_empty_irq_en_next; // enables
    logic [2:0] abort_reg, abort_next;           // abort requests
    logic       busoff_hold_flag_reg, busoff_hold_flag_next; // hold flag
    logic       recov_reg, recov_next;           // recovery pulse
    logic [2:0] irq_reg, irq_next;               // registered irq requests
    logic       ack_reg, ack_next;               // ack flop
    logic [CTAB_DW-1:0] rdat_reg, rdat_next;     // read data flop
    logic       in_init;                         // init mode active
    logic       no_init;                         // both init signals low
    logic       req;                             // new bus request
    logic       wr_lane0;                        // write touching low byte

    assign in_init  = init_mode_request_i && init_mode_acknowledge_i;
    assign no_init  = !init_mode_request_i && !init_mode_acknowledge_i;
    // single-cycle ack, dropped the cycle after it was given
    assign req      = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

    // next-state for bus answer and registers
    always_comb begin
        tx_buffer_empty_irq_en_next = tx_buffer_empty_irq_en_reg;
        abort_next                  = abort_reg;
        busoff_hold_flag_next       = busoff_hold_flag_reg;
        recov_next                  = 1'b0;
        ack_next                    = req;
        rdat_next                   = rdat_reg;
        // sent buffer drops only its own request
        abort_next = abort_next & ~tx_sent_i;
        // writes to mapped registers
        if (wr_lane0 && wb_adr_i == CTAB_OFS_TIER) begin
            if (no_init) begin
                tx_buffer_empty_irq_en_next = wb_dat_i[2:0];
            end
        end else if (wr_lane0 && wb_adr_i == CTAB_OFS_TARQ) begin
            if (no_init) begin
                // set per buffer; clear comes from the sent event
                abort_next = abort_next | wb_dat_i[2:0];
            end
        end else if (wr_lane0 && wb_adr_i == CTAB_OFS_MISC) begin
            if (wb_dat_i[CTAB_HOLD_BIT]) begin
                busoff_hold_flag_next = 1'b0;
                // clearing a set flag starts recovery
                recov_next = busoff_hold_flag_reg;
            end
        end
        // test register writes fall through with no effect
        // entering bus-off with recovery select sets hold; set beats clear
        if (busoff_enter_i && busoff_recovery_select_i) begin
            busoff_hold_flag_next = 1'b1;
            recov_next            = 1'b0;
        end
        // held at reset value during init
        if (in_init) begin
            tx_buffer_empty_irq_en_next = CTAB_RST_BUF;
            abort_next                  = CTAB_RST_BUF;
        end
        // read mux, address decode by if chain
        if (req && !wb_we_i) begin
            if (wb_adr_i == CTAB_OFS_TIER) begin
                rdat_next = {29'h0, tx_buffer_empty_irq_en_reg};
            end else if (wb_adr_i == CTAB_OFS_TARQ) begin
                rdat_next = {29'h0, abort_reg};
            end else if (wb_adr_i == CTAB_OFS_TEST) begin
                rdat_next = CTAB_RD_ZERO;
            end else if (wb_adr_i == CTAB_OFS_MISC) begin
                rdat_next = {31'h0, busoff_hold_flag_reg};
            end else if (wb_adr_i == CTAB_OFS_STAT) begin
                rdat_next = {27'h0, !busoff_hold_flag_reg, busoff_hold_flag_reg, irq_reg};
            end else begin
                // unmapped: acked, reads zero
                rdat_next = CTAB_RD_ZERO;
            end
        end
    end

    // per-buffer irq request generation
    for (genvar b = 0; b < CTAB_NBUF; b++) begin : g_irq
        always_comb begin
            irq_next[b] = tx_empty_event_i[b] && tx_buffer_empty_irq_en_reg[b] && !in_init;
        end
    end

    // register stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_buffer_empty_irq_en_reg <= CTAB_RST_BUF;
            abort_reg                  <= CTAB_RST_BUF;
            busoff_hold_flag_reg       <= 1'b0;
            recov_reg                  <= 1'b0;
            irq_reg                    <= CTAB_RST_BUF;
            ack_reg                    <= 1'b0;
            rdat_reg                   <= CTAB_RD_ZERO;
        end else if (ce_i) begin
            tx_buffer_empty_irq_en_reg <= tx_buffer_empty_irq_en_next;
            abort_reg                  <= abort_next;
            busoff_hold_flag_reg       <= busoff_hold_flag_next;
            recov_reg                  <= recov_next;
            irq_reg                    <= irq_next;
            ack_reg                    <= ack_next;
            rdat_reg                   <= rdat_next;
        end
    end

    assign wb_ack_o            = ack_reg;
    assign wb_dat_o            = rdat_reg;
    assign tx_irq_req_o        = irq_reg;
    assign abort_request_bit_o = abort_reg;
    // block stays bus-off while hold is set
    assign busoff_hold_o       = busoff_hold_flag_reg;
    assign recovery_req_o      = recov_reg;

    // checks: each one is named after the rule it guards
    // all are clocked by the bus clock and quiet while reset is applied
    // most carry ce_i in the antecedent since a frozen cycle keeps state

    a_init_holds_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && in_init |=> tx_buffer_empty_irq_en_reg == CTAB_RST_BUF)
        else $error("irq enable not held during init");

    a_enable_write_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_lane0 && wb_adr_i == CTAB_OFS_TIER && !no_init && !in_init
        |=> $stable(tx_buffer_empty_irq_en_reg))
        else $error("irq enable written outside normal mode");

    a_init_holds_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && in_init |=> abort_reg == CTAB_RST_BUF)
        else $error("abort request not held during init");

    a_abort_write_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !in_init && !no_init && tx_sent_i == 3'h0 |=> $stable(abort_reg))
        else $error("abort request changed outside normal mode");

    a_irq_when_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tx_empty_event_i[0] && tx_buffer_empty_irq_en_reg[0] && !in_init
        |=> tx_irq_req_o[0])
        else $error("enabled empty event gave no irq");

    a_irq_en_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tx_empty_event_i[1] && tx_buffer_empty_irq_en_reg[1] && !in_init
        |=> tx_irq_req_o[1])
        else $error("enabled empty event gave no irq");

    a_irq_en_two: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tx_empty_event_i[2] && tx_buffer_empty_irq_en_reg[2] && !in_init
        |=> tx_irq_req_o[2])
        else $error("enabled empty event gave no irq");

    a_irq_none_init: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && in_init |=> tx_irq_req_o == 3'h0)
        else $error("irq raised during init");

    a_irq_needs_event: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tx_empty_event_i == 3'h0 |=> tx_irq_req_o == 3'h0)
        else $error("irq raised without empty event");

    a_irq_blocked_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !tx_buffer_empty_irq_en_reg[1] |=> !tx_irq_req_o[1])
        else $error("irq raised while disabled");

    a_irq_off_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !tx_buffer_empty_irq_en_reg[0] |=> !tx_irq_req_o[0])
        else $error("irq raised while disabled");

    a_irq_off_two: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !tx_buffer_empty_irq_en_reg[2] |=> !tx_irq_req_o[2])
        else $error("irq raised while disabled");

    a_abort_write_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_lane0 && wb_adr_i == CTAB_OFS_TARQ && no_init && wb_dat_i[2]
        && !tx_sent_i[2] |=> abort_reg[2])
        else $error("abort write did not set bit");

    a_abort_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && abort_reg[0] && !tx_sent_i[0] && !in_init |=> abort_reg[0])
        else $error("abort request dropped without sent event");

    a_test_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && !wb_we_i && wb_adr_i == CTAB_OFS_TEST
        |=> wb_ack_o && wb_dat_o == CTAB_RD_ZERO)
        else $error("test register read not zero");

    a_test_write_inert: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_lane0 && wb_adr_i == CTAB_OFS_TEST && !in_init && tx_sent_i == 3'h0
        && !busoff_enter_i |=> $stable(tx_buffer_empty_irq_en_reg) && $stable(abort_reg)
        && $stable(busoff_hold_flag_reg))
        else $error("test register write changed state");

    a_busoff_sets_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && busoff_enter_i && busoff_recovery_select_i |=> busoff_hold_o)
        else $error("hold flag not set on bus-off");

    a_hold_no_select: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !busoff_hold_o && !(busoff_enter_i && busoff_recovery_select_i)
        |=> !busoff_hold_o)
        else $error("hold flag set without selected bus-off");

    a_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(busoff_hold_o) && $stable(abort_reg))
        else $error("state moved while clock enable low");

    a_hold_ignore_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && busoff_hold_o && !(wr_lane0 && wb_adr_i == CTAB_OFS_MISC && wb_dat_i[0])
        |=> busoff_hold_o)
        else $error("hold flag cleared without write one");

    a_read_acked: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req |=> wb_ack_o)
        else $error("bus request not acknowledged");

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_hold_clear_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && busoff_hold_o && wr_lane0 && wb_adr_i == CTAB_OFS_MISC && wb_dat_i[0]
        && !busoff_enter_i |=> !busoff_hold_o && recovery_req_o)
        else $error("hold clear did not request recovery");

    a_recov_needs_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !(busoff_hold_o && wr_lane0 && wb_adr_i == CTAB_OFS_MISC && wb_dat_i[0])
        |=> !recovery_req_o)
        else $error("recovery requested without a clear");

    a_recov_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && recovery_req_o |=> !recovery_req_o)
        else $error("recovery request longer than one cycle");

    a_abort_own_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tx_sent_i[0] && abort_reg[1] && !in_init |=> abort_reg[1])
        else $error("sent event cleared another buffer");

    a_abort_own_two: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tx_sent_i[1] && abort_reg[2] && !in_init |=> abort_reg[2])
        else $error("sent event cleared another buffer");

    a_abort_sent_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tx_sent_i[1] && !(wr_lane0 && wb_adr_i == CTAB_OFS_TARQ)
        |=> !abort_reg[1])
        else $error("sent event left its abort request");

    // the bus ack and the read word are the only answers software sees;
    // irq, hold and recovery outputs go to the rest of the controller
endmodule
